// [design/buc_uart_core.sv]
// banked serial port core: register window, baud generator, tx and rx
// assumes a single 40 MHz clock, a one-cycle register port, async serial in
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
module buc_uart_core (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port
  input wire logic [buc_pkg::OFS_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // serial line
  input wire logic serial_rx_in,
  output logic serial_tx_out,
  // test clock
  output logic baud_x16_clock_out
);
  import buc_pkg::*;

  logic [1:0] bank_reg;
  logic [6:0] lf_reg;
  logic [7:0] ier_reg, mcr_reg, scr_reg, ext1_reg, ext2_reg;
  logic [15:0] div_reg;
  logic [7:0] lscr_lo_reg, lscr_hi_reg;
  logic fifo_en_reg;
  logic ovr_reg, perr_reg, ferr_reg, brk_reg;
  logic [7:0] rdata_reg;
  logic tx_line_reg, x16_out_reg;
  logic [3:0] presc_cnt_reg;
  logic [15:0] div_cnt_reg;
  logic x16_tick_reg;
  logic [7:0] tx_mem [16];
  logic [7:0] rx_mem [16];
  logic [3:0] tx_wp_reg, tx_rp_reg, rx_wp_reg, rx_rp_reg;
  logic [4:0] tx_cnt_reg, rx_cnt_reg;
  buc_tx_state_type tx_state_reg;
  buc_rx_state_type rx_state_reg;
  logic [3:0] tx_tick_reg, rx_tick_reg;
  logic [2:0] tx_idx_reg, rx_idx_reg;
  logic [7:0] tx_shift_reg, rx_shift_reg;
  logic tx_par_reg, rx_parbit_reg, rx_perr_reg;
  logic rx_s1_reg, rx_s2_reg, rx_s3_reg, rx_lvl_reg;

  // address and bank decode
  logic in_b0, in_b1, in_b2, in_b3, acc;
  logic ext_mode, locked, leg_acc, fallback;
  logic bsel_wr, tx_push_req, rx_pop_req, lsr_clr, fcr_wr;
  assign in_b0 = (bank_reg == BANK0);
  assign in_b1 = (bank_reg == BANK1);
  assign in_b2 = (bank_reg == BANK2);
  assign in_b3 = (bank_reg == BANK3);
  assign acc = reg_wr || reg_rd;
  assign ext_mode = ext1_reg[EXT1_EXT_BIT];
  assign locked = ext2_reg[EXT2_LOCK_BIT] && !ext_mode;
  assign leg_acc = acc && in_b1
    && (reg_addr == OFS_DIV_LO || reg_addr == OFS_DIV_HI);
  assign fallback = leg_acc && !locked;
  assign bsel_wr = reg_wr && (reg_addr == OFS_BANK);
  assign tx_push_req = reg_wr && in_b0 && (reg_addr == OFS_DATA);
  assign rx_pop_req = reg_rd && in_b0 && (reg_addr == OFS_DATA);
  assign lsr_clr = reg_rd && in_b0 && (reg_addr == OFS_LSR);
  assign fcr_wr = reg_wr && in_b0 && (reg_addr == OFS_FCR);

  // per-register write enables
  logic we_ier, we_mcr, we_scr, we_dlo, we_dhi, we_e1, we_e2;
  logic we_slo, we_shi;
  assign we_ier = reg_wr && in_b0 && (reg_addr == OFS_IER);
  assign we_mcr = reg_wr && in_b0 && (reg_addr == OFS_MCR);
  assign we_scr = reg_wr && in_b0 && (reg_addr == OFS_SCR);
  assign we_dlo = reg_wr && reg_addr == OFS_DIV_LO
    && (in_b2 || (in_b1 && !locked));
  assign we_dhi = reg_wr && reg_addr == OFS_DIV_HI
    && (in_b2 || (in_b1 && !locked));
  assign we_e1 = reg_wr && in_b2 && (reg_addr == OFS_EXT1);
  assign we_e2 = reg_wr && in_b2 && (reg_addr == OFS_EXT2);
  assign we_slo = reg_wr && in_b1 && locked && reg_addr == OFS_DIV_LO;
  assign we_shi = reg_wr && in_b1 && locked && reg_addr == OFS_DIV_HI;

  // bank select and line format share offset 3
  logic [1:0] bank_wsel;
  logic ext_sel;
  assign ext_sel = reg_wdata[BSEL_BIT] && (reg_wdata[6:5] == BSEL_EXT_KEY);
  assign bank_wsel = !reg_wdata[BSEL_BIT] ? BANK0 :
    (ext_sel ? reg_wdata[1:0] : BANK1);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bank_reg <= BANK0;
      lf_reg <= LF_RESET;
    end else if (bsel_wr) begin
      bank_reg <= bank_wsel;
      if (!ext_sel)
        lf_reg <= reg_wdata[6:0];
    end
  end

  // plain storage registers of bank 0
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ier_reg <= 8'h00;
      mcr_reg <= 8'h00;
      scr_reg <= 8'h00;
      fifo_en_reg <= 1'b0;
    end else begin
      if (we_ier)
        ier_reg <= ext_mode ? reg_wdata : {4'h0, reg_wdata[3:0]};
      if (we_mcr)
        mcr_reg <= reg_wdata;
      if (we_scr)
        scr_reg <= reg_wdata;
      if (fcr_wr)
        fifo_en_reg <= reg_wdata[FCR_EN_BIT];
    end
  end

  // divisor, extended control and fallback
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg <= DIVISOR_RESET;
      ext1_reg <= EXT1_RESET;
      ext2_reg <= EXT2_RESET;
      lscr_lo_reg <= 8'h00;
      lscr_hi_reg <= 8'h00;
    end else begin
      if (we_dlo)
        div_reg[7:0] <= reg_wdata;
      if (we_dhi)
        div_reg[15:8] <= reg_wdata;
      if (we_slo)
        lscr_lo_reg <= reg_wdata;
      if (we_shi)
        lscr_hi_reg <= reg_wdata;
      if (we_e1)
        ext1_reg <= reg_wdata;
      if (we_e2)
        ext2_reg <= reg_wdata;
      if (fallback) begin
        ext2_reg[3:0] <= PRESCALE_DEFAULT;
        ext1_reg <= ext1_reg & EXT1_FALLBACK_MASK;
      end
    end
  end

  // baud generator: prescaler then 16-bit divisor
  logic [3:0] presc_val;
  logic presc_hit, div_hit;
  assign presc_val = (ext2_reg[3:0] == 4'h0) ? 4'h1 : ext2_reg[3:0];
  assign presc_hit = (presc_cnt_reg >= presc_val - 4'h1);
  assign div_hit = (div_reg != 16'h0000)
    && (div_cnt_reg >= div_reg - 16'h0001);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      presc_cnt_reg <= 4'h0;
      div_cnt_reg <= 16'h0000;
      x16_tick_reg <= 1'b0;
      x16_out_reg <= 1'b0;
    end else begin
      presc_cnt_reg <= presc_hit ? 4'h0 : presc_cnt_reg + 4'h1;
      x16_tick_reg <= presc_hit && div_hit;
      if (presc_hit)
        div_cnt_reg <= div_hit ? 16'h0000 : div_cnt_reg + 16'h0001;
      x16_out_reg <= x16_tick_reg && ext1_reg[EXT1_TEST_BIT];
    end
  end

  // word length helpers
  logic [7:0] wmask, tx_word, rx_word;
  logic [2:0] last_idx;
  logic par_en, par_even;
  logic [4:0] fifo_cap;
  assign wmask = 8'hff >> (3'h3 - {1'b0, lf_reg[1:0]});
  assign last_idx = {1'b1, lf_reg[1:0]};
  assign par_en = lf_reg[LF_PAR_EN_BIT];
  assign par_even = lf_reg[LF_PAR_EVEN_BIT];
  assign fifo_cap = fifo_en_reg ? FIFO_DEPTH : 5'h01;

  // transmit queue
  logic tx_full, tx_idle, tx_push, tx_pop, tx_clr;
  assign tx_full = (tx_cnt_reg >= fifo_cap);
  assign tx_idle = (tx_state_reg == TX_IDLE);
  assign tx_push = tx_push_req && !tx_full;
  assign tx_pop = tx_idle && (tx_cnt_reg != 5'h00) && x16_tick_reg;
  assign tx_clr = fcr_wr && (reg_wdata[FCR_TXCLR_BIT]
    || reg_wdata[FCR_EN_BIT] != fifo_en_reg);
  assign tx_word = tx_mem[tx_rp_reg] & wmask;

  always_ff @(posedge clk) begin
    if (tx_push)
      tx_mem[tx_wp_reg] <= reg_wdata;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_wp_reg <= 4'h0;
      tx_rp_reg <= 4'h0;
      tx_cnt_reg <= 5'h00;
    end else if (tx_clr) begin
      tx_wp_reg <= 4'h0;
      tx_rp_reg <= 4'h0;
      tx_cnt_reg <= 5'h00;
    end else begin
      if (tx_push)
        tx_wp_reg <= tx_wp_reg + 4'h1;
      if (tx_pop)
        tx_rp_reg <= tx_rp_reg + 4'h1;
      tx_cnt_reg <= tx_cnt_reg + {4'h0, tx_push} - {4'h0, tx_pop};
    end
  end

  // transmit shifter, sixteen x16 ticks per bit
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_state_reg <= TX_IDLE;
      tx_tick_reg <= 4'h0;
      tx_idx_reg <= 3'h0;
      tx_shift_reg <= 8'h00;
      tx_par_reg <= 1'b0;
    end else if (tx_pop) begin
      tx_state_reg <= TX_START;
      tx_tick_reg <= 4'h0;
      tx_shift_reg <= tx_word;
      tx_par_reg <= par_even ? ^tx_word : ~^tx_word;
    end else if (x16_tick_reg && !tx_idle) begin
      tx_tick_reg <= tx_tick_reg + 4'h1;
      if (tx_tick_reg == TICK_LAST) begin
        unique case (tx_state_reg)
          TX_START: begin
            tx_state_reg <= TX_DATA;
            tx_idx_reg <= 3'h0;
          end
          TX_DATA: begin
            tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            tx_idx_reg <= tx_idx_reg + 3'h1;
            if (tx_idx_reg == last_idx)
              tx_state_reg <= par_en ? TX_PAR : TX_STOP;
          end
          TX_PAR: tx_state_reg <= TX_STOP;
          TX_STOP: tx_state_reg <= TX_IDLE;
          default: tx_state_reg <= TX_IDLE;
        endcase
      end
    end
  end

  // line level from transmit state
  logic tx_raw, tx_int, loop_en;
  assign loop_en = ext1_reg[EXT1_LOOP_BIT];
  assign tx_raw = (tx_state_reg == TX_START) ? 1'b0 :
    (tx_state_reg == TX_DATA) ? tx_shift_reg[0] :
    (tx_state_reg == TX_PAR) ? tx_par_reg : 1'b1;
  assign tx_int = tx_raw && !lf_reg[LF_BREAK_BIT];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      tx_line_reg <= 1'b1;
    else
      tx_line_reg <= loop_en ? 1'b1 : tx_int;
  end

  // receive input synchroniser, change taken when stages two and three agree
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rx_s3_reg <= 1'b1;
      rx_lvl_reg <= 1'b1;
    end else begin
      rx_s1_reg <= serial_rx_in;
      rx_s2_reg <= rx_s1_reg;
      rx_s3_reg <= rx_s2_reg;
      if (rx_s2_reg == rx_s3_reg)
        rx_lvl_reg <= rx_s3_reg;
    end
  end

  // receive shifter, runs apart from the transmitter
  logic rx_in, rx_done, rx_full, rx_push, rx_pop, rx_clr, rx_stop_bad;
  assign rx_in = loop_en ? tx_int : rx_lvl_reg;
  assign rx_word = rx_shift_reg >> (3'h3 - {1'b0, lf_reg[1:0]});
  assign rx_done = x16_tick_reg && (rx_state_reg == RX_STOP)
    && (rx_tick_reg == TICK_LAST);
  assign rx_full = (rx_cnt_reg >= fifo_cap);
  assign rx_push = rx_done && !rx_full;
  assign rx_pop = rx_pop_req && (rx_cnt_reg != 5'h00);
  assign rx_clr = fcr_wr && (reg_wdata[FCR_RXCLR_BIT]
    || reg_wdata[FCR_EN_BIT] != fifo_en_reg);
  assign rx_stop_bad = !rx_in;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_state_reg <= RX_IDLE;
      rx_tick_reg <= 4'h0;
      rx_idx_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_parbit_reg <= 1'b0;
      rx_perr_reg <= 1'b0;
    end else if (x16_tick_reg) begin
      rx_tick_reg <= rx_tick_reg + 4'h1;
      unique case (rx_state_reg)
        RX_IDLE: begin
          rx_tick_reg <= 4'h0;
          if (!rx_in)
            rx_state_reg <= RX_START;
        end
        RX_START: if (rx_tick_reg == TICK_MID) begin
          rx_tick_reg <= 4'h0;
          rx_idx_reg <= 3'h0;
          rx_parbit_reg <= 1'b0;
          rx_perr_reg <= 1'b0;
          rx_state_reg <= rx_in ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rx_tick_reg == TICK_LAST) begin
          rx_shift_reg <= {rx_in, rx_shift_reg[7:1]};
          rx_idx_reg <= rx_idx_reg + 3'h1;
          if (rx_idx_reg == last_idx)
            rx_state_reg <= par_en ? RX_PAR : RX_STOP;
        end
        RX_PAR: if (rx_tick_reg == TICK_LAST) begin
          rx_parbit_reg <= rx_in;
          rx_perr_reg <= (^rx_word) ^ rx_in ^ !par_even;
          rx_state_reg <= RX_STOP;
        end
        RX_STOP: if (rx_tick_reg == TICK_LAST)
          rx_state_reg <= RX_IDLE;
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // receive queue
  always_ff @(posedge clk) begin
    if (rx_push)
      rx_mem[rx_wp_reg] <= rx_word;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_wp_reg <= 4'h0;
      rx_rp_reg <= 4'h0;
      rx_cnt_reg <= 5'h00;
    end else if (rx_clr) begin
      rx_wp_reg <= 4'h0;
      rx_rp_reg <= 4'h0;
      rx_cnt_reg <= 5'h00;
    end else begin
      if (rx_push)
        rx_wp_reg <= rx_wp_reg + 4'h1;
      if (rx_pop)
        rx_rp_reg <= rx_rp_reg + 4'h1;
      rx_cnt_reg <= rx_cnt_reg + {4'h0, rx_push} - {4'h0, rx_pop};
    end
  end

  // sticky line errors, a new event beats the read clear
  logic brk_set;
  assign brk_set = rx_done && rx_stop_bad && (rx_word == 8'h00)
    && !(par_en && rx_parbit_reg);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ovr_reg <= 1'b0;
      perr_reg <= 1'b0;
      ferr_reg <= 1'b0;
      brk_reg <= 1'b0;
    end else begin
      ovr_reg <= (rx_done && rx_full) || (ovr_reg && !lsr_clr);
      perr_reg <= (rx_done && par_en && rx_perr_reg)
        || (perr_reg && !lsr_clr);
      ferr_reg <= (rx_done && rx_stop_bad) || (ferr_reg && !lsr_clr);
      brk_reg <= brk_set || (brk_reg && !lsr_clr);
    end
  end

  // status and read views per bank
  logic [7:0] lsr_val, bank_view, leg_lo, leg_hi, rd_mux;
  logic [7:0] b0v [8];
  logic [7:0] b1v [8];
  logic [7:0] b2v [8];
  logic [7:0] b3v [8];
  assign lsr_val = {ovr_reg || perr_reg || ferr_reg || brk_reg,
    tx_cnt_reg == 5'h00 && tx_idle, tx_cnt_reg == 5'h00,
    brk_reg, ferr_reg, perr_reg, ovr_reg, rx_cnt_reg != 5'h00};
  assign bank_view = (in_b0 || in_b1) ? {!in_b0, lf_reg}
    : {1'b1, BSEL_EXT_KEY, 3'h0, bank_reg};
  assign leg_lo = locked ? lscr_lo_reg : div_reg[7:0];
  assign leg_hi = locked ? lscr_hi_reg : div_reg[15:8];
  assign b0v = '{rx_mem[rx_rp_reg], ier_reg,
    {fifo_en_reg, fifo_en_reg, 6'h00} | IDENT_IDLE, bank_view,
    mcr_reg, lsr_val, 8'h00, scr_reg};
  assign b1v = '{leg_lo, leg_hi, 8'h00, bank_view,
    8'h00, 8'h00, 8'h00, 8'h00};
  assign b2v = '{div_reg[7:0], div_reg[15:8], ext1_reg, bank_view,
    ext2_reg, 8'h00, 8'h00, 8'h00};
  assign b3v = '{REVISION_ID, 8'h00, 8'h00, bank_view,
    8'h00, lsr_val, 8'h00, 8'h00};
  assign rd_mux = in_b0 ? b0v[reg_addr] : in_b1 ? b1v[reg_addr]
    : in_b2 ? b2v[reg_addr] : b3v[reg_addr];

  // read data in the cycle after the strobe only
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= reg_rd ? rd_mux : 8'h00;
  end

  assign reg_rdata = rdata_reg;
  assign serial_tx_out = tx_line_reg;
  assign baud_x16_clock_out = x16_out_reg;
endmodule // buc_uart_core

// [design/buc_pkg.sv]
// constants, field positions and state types for the banked serial port core
// assumes one 40 MHz clock and an 8-location register window
package buc_pkg;
  localparam int OFS_W = 3;
  // register offsets within the window
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_IER = 3'h1;
  localparam logic [2:0] OFS_FCR = 3'h2;
  localparam logic [2:0] OFS_BANK = 3'h3;
  localparam logic [2:0] OFS_MCR = 3'h4;
  localparam logic [2:0] OFS_LSR = 3'h5;
  localparam logic [2:0] OFS_MSR = 3'h6;
  localparam logic [2:0] OFS_SCR = 3'h7;
  localparam logic [2:0] OFS_DIV_LO = 3'h0;
  localparam logic [2:0] OFS_DIV_HI = 3'h1;
  localparam logic [2:0] OFS_EXT1 = 3'h2;
  localparam logic [2:0] OFS_EXT2 = 3'h4;
  localparam logic [2:0] OFS_REV = 3'h0;
  localparam logic [2:0] OFS_SHADOW_LSR = 3'h5;
  // bank codes
  localparam logic [1:0] BANK0 = 2'h0;
  localparam logic [1:0] BANK1 = 2'h1;
  localparam logic [1:0] BANK2 = 2'h2;
  localparam logic [1:0] BANK3 = 2'h3;
  // bank select write fields
  localparam int BSEL_BIT = 7;
  localparam logic [1:0] BSEL_EXT_KEY = 2'h3;
  // line format fields
  localparam int LF_PAR_EN_BIT = 3;
  localparam int LF_PAR_EVEN_BIT = 4;
  localparam int LF_BREAK_BIT = 6;
  localparam logic [6:0] LF_RESET = 7'h00;
  // FIFO control fields
  localparam int FCR_EN_BIT = 0;
  localparam int FCR_RXCLR_BIT = 1;
  localparam int FCR_TXCLR_BIT = 2;
  // extended control fields
  localparam int EXT1_EXT_BIT = 0;
  localparam int EXT1_LOOP_BIT = 4;
  localparam int EXT1_TEST_BIT = 7;
  localparam logic [7:0] EXT1_RESET = 8'h00;
  localparam int EXT2_LOCK_BIT = 7;
  localparam logic [3:0] PRESCALE_DEFAULT = 4'hd;
  localparam logic [7:0] EXT2_RESET = 8'h0d;
  localparam logic [7:0] EXT1_FALLBACK_MASK = 8'h6e;
  localparam logic [15:0] DIVISOR_RESET = 16'h000c;
  // revision code, value arbitrary
  localparam logic [7:0] REVISION_ID = 8'h5a;
  // FIFO and oversampling
  localparam logic [4:0] FIFO_DEPTH = 5'h10;
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [7:0] IDENT_IDLE = 8'h01;
  // one-hot channel states
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04,
    TX_PAR = 5'h08, TX_STOP = 5'h10
  } buc_tx_state_type;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04,
    RX_PAR = 5'h08, RX_STOP = 5'h10
  } buc_rx_state_type;
endpackage

// [bench/buc_uart_core_sva.sv]
// checker: register view and pin relations of the serial port core
// assumes binding to buc_uart_core and one register strobe per cycle
`timescale 1ns/1ps
module buc_uart_core_sva (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // register port
  input wire logic [buc_pkg::OFS_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // serial pins
  input wire logic serial_rx_in,
  input wire logic serial_tx_out,
  input wire logic baud_x16_clock_out
);
  import buc_pkg::*;
  logic [1:0] bank_reg;
  logic [6:0] fmt_reg;
  logic [7:0] ext1_reg;
  logic [7:0] ext2_reg;
  logic test_old_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // decode of bank writes, extended writes and legacy fallback
  wire bank_wr = reg_wr && reg_addr == OFS_BANK;
  wire key_hit = reg_wdata[BSEL_BIT] && reg_wdata[6:5] == BSEL_EXT_KEY;
  wire ext_wr = reg_wr && bank_reg == BANK2;
  wire locked = ext2_reg[EXT2_LOCK_BIT] && !ext1_reg[EXT1_EXT_BIT];
  wire fall_back = (reg_wr || reg_rd) && bank_reg == BANK1
    && reg_addr[2:1] == 2'h0 && !locked;
  wire [7:0] bank_view = bank_reg[1] ? {6'h38, bank_reg}
    : {bank_reg != BANK0, fmt_reg};
  // shadow copy of the host-visible control state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bank_reg <= BANK0;
      fmt_reg <= LF_RESET;
      ext1_reg <= EXT1_RESET;
      ext2_reg <= EXT2_RESET;
      test_old_reg <= 1'b0;
    end else begin
      test_old_reg <= ext1_reg[EXT1_TEST_BIT];
      if (bank_wr && !key_hit)
        fmt_reg <= reg_wdata[6:0];
      if (bank_wr)
        bank_reg <= !reg_wdata[BSEL_BIT] ? BANK0
          : key_hit ? reg_wdata[1:0] : BANK1;
      if (ext_wr && reg_addr == OFS_EXT1)
        ext1_reg <= reg_wdata;
      if (ext_wr && reg_addr == OFS_EXT2)
        ext2_reg <= reg_wdata;
      if (fall_back)
        ext1_reg <= ext1_reg & EXT1_FALLBACK_MASK;
      if (fall_back)
        ext2_reg[3:0] <= PRESCALE_DEFAULT;
    end
  end
  a_rdata_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray read data");
  a_tx_mark_reset: assert property (
    $rose(arst_n) |-> serial_tx_out [*2]) else $error("line not at mark");
  a_rev_read: assert property (
    reg_rd && bank_reg == BANK3 && reg_addr == OFS_REV
    |=> reg_rdata == REVISION_ID) else $error("revision read wrong");
  a_bank_view: assert property (
    reg_rd && reg_addr == OFS_BANK |=> reg_rdata == $past(bank_view))
    else $error("bank select read wrong");
  a_bank3_hole: assert property (
    reg_rd && bank_reg == BANK3 && reg_addr == 3'h1
    |=> reg_rdata == 8'h00) else $error("empty slot not zero");
  a_ext1_fallback: assert property (
    reg_rd && bank_reg == BANK2 && reg_addr == OFS_EXT1
    |=> (reg_rdata & 8'h91) == ($past(ext1_reg) & 8'h91))
    else $error("extended control one wrong");
  a_prescale_view: assert property (
    reg_rd && bank_reg == BANK2 && reg_addr == OFS_EXT2
    |=> (reg_rdata & 8'h8f) == ($past(ext2_reg) & 8'h8f))
    else $error("extended control two wrong");
  a_test_out_gate: assert property (
    !test_old_reg && !ext1_reg[EXT1_TEST_BIT] |-> !baud_x16_clock_out)
    else $error("test clock out while disabled");
endmodule // buc_uart_core_sva

bind buc_uart_core buc_uart_core_sva u_sva (
  .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .serial_rx_in(serial_rx_in), .serial_tx_out(serial_tx_out),
  .baud_x16_clock_out(baud_x16_clock_out)
);

// [bench/buc_serial_peer.sv]
// remote serial peer: decodes frames from the core, sends frames to it
// assumes the bench sets bit length, word length and parity to match
`timescale 1ns/1ps
module buc_serial_peer (
  // clock and line
  input wire logic clk,
  input wire logic tx_line,
  output logic rx_line,
  // frame settings
  input wire logic [15:0] bit_clks,
  input wire logic [3:0] nbits,
  input wire logic par_en,
  // last decoded frame
  output logic [7:0] got_data,
  output logic got_par,
  output logic got_stop,
  output logic [7:0] got_cnt
);
  initial begin
    rx_line = 1'b1;
    got_cnt = 8'h00;
  end
  // decode one frame, sampling each bit at its middle
  always begin
    @(negedge tx_line);
    repeat (bit_clks / 2) @(posedge clk);
    got_data = 8'h00;
    for (int i = 0; i < nbits; i++) begin
      repeat (bit_clks) @(posedge clk);
      got_data[i] = tx_line;
    end
    if (par_en) begin
      repeat (bit_clks) @(posedge clk);
      got_par = tx_line;
    end
    repeat (bit_clks) @(posedge clk);
    got_stop = tx_line;
    got_cnt = got_cnt + 8'h01;
  end
  // send one frame; a bad stop is held low for three quarters of a bit
  task automatic send(input logic [7:0] d, input logic stop_ok);
    @(posedge clk);
    rx_line <= 1'b0;
    repeat (bit_clks) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      rx_line <= d[i];
      repeat (bit_clks) @(posedge clk);
    end
    rx_line <= stop_ok;
    repeat (stop_ok ? bit_clks : bit_clks * 3 / 4) @(posedge clk);
    rx_line <= 1'b1;
  endtask
endmodule // buc_serial_peer

// [bench/buc_uart_core_tb.sv]
// self-checking bench for the banked serial port core
// assumes the serial peer model and the checker are compiled before it
`timescale 1ns/1ps
module buc_uart_core_tb;
  import buc_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic serial_rx_in;
  logic serial_tx_out;
  logic baud_x16_clock_out;
  logic [15:0] bit_clks = 16'h0010;
  logic [3:0] nbits = 4'h8;
  logic par_en = 1'b0;
  logic [7:0] got_data;
  logic got_par;
  logic got_stop;
  logic [7:0] got_cnt;
  int num_errors = 0;
  int checked = 0;
  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  buc_uart_core uut (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_rx_in(serial_rx_in), .serial_tx_out(serial_tx_out),
    .baud_x16_clock_out(baud_x16_clock_out)
  );
  buc_serial_peer peer (
    .clk(clk), .tx_line(serial_tx_out), .rx_line(serial_rx_in),
    .bit_clks(bit_clks), .nbits(nbits), .par_en(par_en),
    .got_data(got_data), .got_par(got_par), .got_stop(got_stop),
    .got_cnt(got_cnt)
  );
  // compare and report
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic complete_run();
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one clock of a bounded wait; running out ends the run
  task automatic step(inout int k);
    @(posedge clk);
    k++;
    if (k > 30000) begin
      num_errors++;
      complete_run();
    end
  endtask
  // register port cycles
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    check(v, exp);
  endtask
  task automatic wait_peer(input logic [7:0] n);
    int k;
    k = 0;
    while (got_cnt !== n)
      step(k);
  endtask
  // reset values in banks 0, 3 and 2
  task automatic t_reset_view();
    check(serial_tx_out, 1'b1);
    check(baud_x16_clock_out, 1'b0);
    rdc(OFS_BANK, 8'h00);
    rdc(OFS_LSR, 8'h60);
    rdc(OFS_FCR, 8'h01);
    rdc(OFS_MSR, 8'h00);
    wr(OFS_BANK, 8'he3);
    rdc(OFS_BANK, 8'he3);
    rdc(OFS_REV, REVISION_ID);
    rdc(3'h1, 8'h00);
    wr(OFS_BANK, 8'he2);
    rdc(OFS_EXT1, EXT1_RESET);
    rdc(OFS_EXT2, EXT2_RESET);
    rdc(OFS_DIV_LO, DIVISOR_RESET[7:0]);
    rdc(OFS_DIV_HI, DIVISOR_RESET[15:8]);
  endtask
  // transmit in several word lengths and parity settings
  task automatic t_tx_formats();
    logic [7:0] fmt [4] = '{8'h00, 8'h1b, 8'h0a, 8'h03};
    logic [7:0] d;
    logic [7:0] n;
    wr(OFS_DIV_LO, 8'h01);
    wr(OFS_DIV_HI, 8'h00);
    wr(OFS_EXT2, 8'h01);
    for (int i = 0; i < 4; i++) begin
      nbits = 4'h5 + {2'h0, fmt[i][1:0]};
      par_en = fmt[i][3];
      d = (8'h9d ^ 8'(i)) & (8'hff >> (2'h3 - fmt[i][1:0]));
      n = got_cnt + 8'h01;
      wr(OFS_BANK, fmt[i]);
      wr(OFS_DATA, 8'h9d ^ 8'(i));
      wait_peer(n);
      check(got_data, d);
      if (par_en)
        check(got_par, fmt[i][4] ? ^d : ~^d);
      check(got_stop, 1'b1);
    end
    // the peer reports at mid stop bit; let the shifter go idle first
    repeat (16) @(posedge clk);
    rdc(OFS_LSR, 8'h60);
  endtask
  // both directions at once, then overrun and framing faults
  task automatic t_rx_duplex();
    logic [7:0] v;
    logic [7:0] n;
    int k;
    n = got_cnt + 8'h01;
    wr(OFS_DATA, 8'h96);
    peer.send(8'h3c, 1'b1);
    wait_peer(n);
    check(got_data, 8'h96);
    rdc(OFS_DATA, 8'h3c);
    peer.send(8'h11, 1'b1);
    peer.send(8'h22, 1'b1);
    rdc(OFS_LSR, 8'he3);
    rdc(OFS_DATA, 8'h11);
    peer.send(8'h55, 1'b0);
    wr(OFS_BANK, 8'he3);
    k = 0;
    do begin
      rd(OFS_SHADOW_LSR, v);
      step(k);
    end while (v[0] !== 1'b1);
    rdc(OFS_SHADOW_LSR, 8'he9);
    wr(OFS_BANK, 8'h03);
    rdc(OFS_LSR, 8'he9);
    rdc(OFS_LSR, 8'h61);
    rdc(OFS_DATA, 8'h55);
  endtask
  // queue of sixteen, the seventeenth frame overruns
  task automatic t_fifo_depth();
    wr(OFS_FCR, 8'h01);
    rdc(OFS_FCR, 8'hc1);
    for (int i = 0; i < 17; i++)
      peer.send(8'h20 + 8'(i), 1'b1);
    rdc(OFS_LSR, 8'he3);
    for (int i = 0; i < 16; i++)
      rdc(OFS_DATA, 8'h20 + 8'(i));
    rdc(OFS_LSR, 8'h60);
  endtask
  // test clock out, fallback on legacy access, then locked scratch
  task automatic t_fallback();
    logic [7:0] n;
    int k;
    wr(OFS_BANK, 8'he2);
    wr(OFS_EXT1, 8'h81);
    k = 0;
    while (baud_x16_clock_out !== 1'b1)
      step(k);
    check(baud_x16_clock_out, 1'b1);
    wr(OFS_BANK, 8'h83);
    rdc(OFS_DIV_LO, 8'h01);
    wr(OFS_BANK, 8'he2);
    rdc(OFS_EXT1, 8'h00);
    rdc(OFS_EXT2, 8'h0d);
    check(baud_x16_clock_out, 1'b0);
    bit_clks = 16'h00d0;
    n = got_cnt + 8'h01;
    wr(OFS_BANK, 8'h03);
    wr(OFS_DATA, 8'h4b);
    wait_peer(n);
    check(got_data, 8'h4b);
    wr(OFS_BANK, 8'he2);
    wr(OFS_EXT2, 8'h81);
    wr(OFS_BANK, 8'h83);
    wr(OFS_DIV_LO, 8'h07);
    rdc(OFS_DIV_LO, 8'h07);
    wr(OFS_BANK, 8'he2);
    rdc(OFS_DIV_LO, 8'h01);
    rdc(OFS_EXT2, 8'h81);
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_reset_view();
    t_tx_formats();
    t_rx_duplex();
    t_fifo_depth();
    t_fallback();
    complete_run();
  end
endmodule // buc_uart_core_tb
